/* File: verilog/alert_response.sv */
/*
 Alert line logic: software suppress mask, automatic response mask set on a
 won alert response read, address strap decode and open-drain alert drive.
 Assumes fault levels, command strobes and bit ticks come from logic on
 i_clk; pins (address straps, enable, data line) are asynchronous.
*/
`default_nettype none

module alert_response (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Fault conditions from detection logic
   input wire logic [alert_resp_pkg::FAULT_W-1:0] i_fault_active,
   // Command port from the command decoder
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_cmd,
   input wire logic [alert_resp_pkg::FAULT_W-1:0] i_reg_wdata,
   input wire logic i_clear_faults,
   output logic [alert_resp_pkg::FAULT_W-1:0] o_reg_rdata,
   // Response read sequencing from the bus slave
   input wire logic i_ara_start,
   input wire logic i_bit_tick,
   // Data line pin
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe,
   // Alert line pin, active low open drain
   output logic o_alert_n_out,
   output logic o_alert_n_oe,
   // Address strap and enable pins
   input wire logic [1:0] i_addr_select_pin_0,
   input wire logic [1:0] i_addr_select_pin_1,
   input wire logic [1:0] i_addr_select_pin_2,
   input wire logic i_enable,
   // Status and address read-back
   output logic [alert_resp_pkg::FAULT_W-1:0] o_status_active,
   output logic [alert_resp_pkg::ADDR_W-1:0] o_own_addr,
   output logic o_ara_won
);
   import alert_resp_pkg::*;

   logic [FAULT_W-1:0] alert_suppress_mask_r;
   logic [FAULT_W-1:0] auto_response_suppress_r;
   logic [FAULT_W-1:0] auto_response_suppress_nxt;
   logic [FAULT_W-1:0] unmasked;
   logic alerting;
   logic [5:0] pin_meta_r;
   logic [5:0] pin_sync_r;
   logic [1:0] en_sync_r;
   logic en_prev_r;
   logic [1:0] sda_sync_r;
   logic won;
   logic [4:0] addr_index;
   logic [ADDR_W-1:0] addr_decoded;

   // Two-stage synchronisers for the asynchronous pins
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pin_meta_r <= '0;
         pin_sync_r <= '0;
         en_sync_r <= 2'h0;
         sda_sync_r <= 2'h3;
      end else begin
         pin_meta_r <= {i_addr_select_pin_2, i_addr_select_pin_1, i_addr_select_pin_0};
         pin_sync_r <= pin_meta_r;
         en_sync_r <= {en_sync_r[0], i_enable};
         sda_sync_r <= {sda_sync_r[0], i_sda};
      end
   end

   // Tri-level decode of the address straps
   function automatic logic [1:0] tri_index(input logic [1:0] lvl);
      case (lvl)
         TRI_LOW: tri_index = 2'h1;
         TRI_HIGH: tri_index = 2'h2;
         default: tri_index = 2'h0;
      endcase
   endfunction : tri_index

   assign addr_index = 5'(tri_index(pin_sync_r[5:4]) * TRI_LEVELS * TRI_LEVELS)
                     + 5'(tri_index(pin_sync_r[3:2]) * TRI_LEVELS)
                     + 5'(tri_index(pin_sync_r[1:0]));
   assign addr_decoded = (addr_index < 5'(ADDR_COUNT)) ? ADDR_TABLE[addr_index]
                                                      : ADDR_FALLBACK;

   // Latch the address when enable returns high after reset
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         en_prev_r <= 1'b0;
         o_own_addr <= ADDR_FALLBACK;
      end else begin
         en_prev_r <= en_sync_r[1];
         if (en_sync_r[1] && !en_prev_r) begin
            o_own_addr <= addr_decoded;
         end
      end
   end

   // Software alert suppress mask
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         alert_suppress_mask_r <= ALERT_MASK_RESET;
      end else if (i_reg_wr && i_reg_cmd == CMD_ALERT_SUPPRESS_MASK) begin
         alert_suppress_mask_r <= i_reg_wdata;
      end
   end

   // Automatic mask: set on a win wins over a same-cycle clear
   always_comb begin
      auto_response_suppress_nxt = auto_response_suppress_r;
      if (i_clear_faults) begin
         auto_response_suppress_nxt = '0;
      end
      if (won) begin
         // Only faults present now are covered
         auto_response_suppress_nxt = auto_response_suppress_nxt | i_fault_active;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         auto_response_suppress_r <= '0;
      end else begin
         auto_response_suppress_r <= auto_response_suppress_nxt;
      end
   end

   // Alert qualification through both masks
   assign unmasked = i_fault_active & ~alert_suppress_mask_r & ~auto_response_suppress_r;
   assign alerting = |unmasked;

   // Open-drain alert drive, released by own masks or by a win
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_alert_n_oe <= 1'b0;
      end else begin
         o_alert_n_oe <= alerting & ~won;
      end
   end
   assign o_alert_n_out = 1'b0;

   // Status mirror, untouched by either mask
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_status_active <= '0;
         o_ara_won <= 1'b0;
      end else begin
         o_status_active <= i_fault_active;
         o_ara_won <= won;
      end
   end

   // Register read-back
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_reg_rdata <= '0;
      end else if (i_reg_rd) begin
         o_reg_rdata <= (i_reg_cmd == CMD_ALERT_SUPPRESS_MASK) ? alert_suppress_mask_r : '0;
      end
   end

   // Address arbitration during the response read
   ara_arbiter u_arbiter (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_ara_start(i_ara_start),
      .i_bit_tick(i_bit_tick),
      .i_sda_level(sda_sync_r[1]),
      .i_alerting(o_alert_n_oe),
      .i_own_addr(o_own_addr),
      .o_sda_oe(o_sda_oe),
      .o_won(won)
   );
   assign o_sda_out = 1'b0;

endmodule : alert_response

`default_nettype wire

/* File: verilog/alert_resp_pkg.sv */
/*
 Holds the shared constants of the alert response logic: command code of the
 software alert mask, its width and reset value, the tri-level pin codes and
 the address decode table.
 Assumes nothing of its surroundings.
*/
`default_nettype none

package alert_resp_pkg;

   // Width of the fault condition vector and its masks
   localparam int FAULT_W = 16;
   // Command code of the software alert mask register
   localparam logic [7:0] CMD_ALERT_SUPPRESS_MASK = 8'hD8;
   // Reset value of the software mask (nothing suppressed)
   localparam logic [FAULT_W-1:0] ALERT_MASK_RESET = 16'h0000;

   // Bus address width and address bit count sent during arbitration
   localparam int ADDR_W = 7;
   localparam logic [2:0] ADDR_LAST_BIT = 3'h6;
   localparam logic [2:0] ADDR_FIRST_BIT = 3'h0;

   // Sensed level of one tri-level address pin
   localparam logic [1:0] TRI_OPEN = 2'h0;
   localparam logic [1:0] TRI_LOW = 2'h1;
   localparam logic [1:0] TRI_HIGH = 2'h2;
   localparam int TRI_LEVELS = 3;
   localparam int ADDR_COUNT = 27;
   localparam logic [ADDR_W-1:0] ADDR_FALLBACK = 7'h40;

   // Decoded address, indexed pin2*9 + pin1*3 + pin0 (open=0, low=1, high=2)
   localparam logic [ADDR_W-1:0] ADDR_TABLE [ADDR_COUNT] = '{
      7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46, 7'h47, 7'h10,
      7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h50, 7'h51,
      7'h52, 7'h53, 7'h54, 7'h55, 7'h56, 7'h57, 7'h58, 7'h59, 7'h5A
   };

   // Arbitration engine states
   typedef enum logic [0:0] {
      ARB_IDLE = 1'b0,
      ARB_SEND = 1'b1
   } arb_state_t;

endpackage : alert_resp_pkg

`default_nettype wire

/* File: verilog/ara_arbiter.sv */
/*
 Address arbitration engine for the alert response read: shifts the own
 address out MSB first on the open-drain data line and drops out when a
 lower address from another device pulls the line low.
 Assumes the bus slave gives a start pulse and one sample tick per address
 bit, all on i_clk, and that the data input is already synchronised.
*/
`default_nettype none

module ara_arbiter (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Bus slave sequencing
   input wire logic i_ara_start,
   input wire logic i_bit_tick,
   input wire logic i_sda_level,
   // Device state
   input wire logic i_alerting,
   input wire logic [alert_resp_pkg::ADDR_W-1:0] i_own_addr,
   // Data line drive and result
   output logic o_sda_oe,
   output logic o_won
);
   import alert_resp_pkg::*;

   arb_state_t state_r;
   logic [2:0] bit_r;
   logic [ADDR_W-1:0] shift_r;
   logic my_bit;
   logic lost;

   // Current bit offered and loss detection
   assign my_bit = shift_r[ADDR_W-1];
   assign lost = my_bit & ~i_sda_level;
   // Drive low for a zero bit while still arbitrating
   assign o_sda_oe = (state_r == ARB_SEND) & ~my_bit;

   // Arbitration sequence
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_r <= ARB_IDLE;
         bit_r <= ADDR_FIRST_BIT;
         shift_r <= '0;
         o_won <= 1'b0;
      end else begin
         o_won <= 1'b0;
         case (state_r)
            ARB_IDLE: begin
               // Only an alerting device takes part
               if (i_ara_start && i_alerting) begin
                  state_r <= ARB_SEND;
                  bit_r <= ADDR_FIRST_BIT;
                  shift_r <= i_own_addr;
               end
            end
            ARB_SEND: begin
               if (i_ara_start) begin
                  bit_r <= ADDR_FIRST_BIT;
                  shift_r <= i_own_addr;
               end else if (i_bit_tick) begin
                  if (lost) begin
                     state_r <= ARB_IDLE;
                  end else if (bit_r == ADDR_LAST_BIT) begin
                     state_r <= ARB_IDLE;
                     o_won <= 1'b1;
                  end else begin
                     bit_r <= bit_r + 3'h1;
                     shift_r <= {shift_r[ADDR_W-2:0], 1'b0};
                  end
               end
            end
            default: begin
               state_r <= ARB_IDLE;
            end
         endcase
      end
   end

endmodule : ara_arbiter

`default_nettype wire

/* File: dv/alert_response_asserts.sv */
/* Checker of the alert response block ports.
   Assumes a bind onto alert_response from the bench. */
`default_nettype none
module alert_response_checker (
   // Clock, reset and inputs
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [alert_resp_pkg::FAULT_W-1:0] i_fault_active,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_cmd,
   input wire logic i_clear_faults,
   // Outputs watched
   input wire logic [alert_resp_pkg::FAULT_W-1:0] o_reg_rdata,
   input wire logic o_sda_out,
   input wire logic o_sda_oe,
   input wire logic o_alert_n_out,
   input wire logic o_alert_n_oe,
   input wire logic [alert_resp_pkg::FAULT_W-1:0] o_status_active,
   input wire logic o_ara_won
);
   timeunit 1ns;
   timeprecision 1ns;
   import alert_resp_pkg::*;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   // Win step, and a quiet spell after which the alert must stay released
   sequence s_win;
      o_ara_won;
   endsequence
   sequence s_quiet;
      !o_alert_n_oe && $stable(i_fault_active) && !i_clear_faults && !$past(i_clear_faults)
         && !i_reg_wr && !$past(i_reg_wr);
   endsequence
   a_pins_only_low: assert property (!o_sda_out && !o_alert_n_out)
      else $error("open drain pin driven high");
   a_status_follows: assert property ($past(i_reset_n) |-> o_status_active == $past(i_fault_active))
      else $error("status not a copy of faults");
   a_win_releases: assert property (s_win |-> !o_alert_n_oe && !o_sda_oe)
      else $error("alert still driven after win");
   a_win_single: assert property (s_win |=> !o_ara_won)
      else $error("win longer than one cycle");
   a_idle_quiet: assert property (i_fault_active == '0 |=> !o_alert_n_oe)
      else $error("alert without fault");
   a_rise_cause: assert property ($rose(o_alert_n_oe) |-> $past(i_fault_active) != '0)
      else $error("alert rose without fault");
   a_masked_hold: assert property (s_quiet |=> !o_alert_n_oe)
      else $error("masked fault alerted again");
   a_unmapped_zero: assert property (i_reg_rd && i_reg_cmd != CMD_ALERT_SUPPRESS_MASK |=> o_reg_rdata == '0)
      else $error("unmapped read not zero");
endmodule : alert_response_checker
`default_nettype wire

/* File: dv/bus_side_model.sv */
/* Far side of the data and alert lines: pull-ups and one rival device.
   Assumes start and tick pulses on i_clk, as the block sees them. */
`default_nettype none
module bus_side_model (
   // Clock and block drives
   input wire logic i_clk,
   input wire logic i_dut_sda_oe,
   input wire logic i_dut_alert_oe,
   input wire logic i_ara_start,
   input wire logic i_bit_tick,
   // Rival device
   input wire logic i_rival_on,
   input wire logic [6:0] i_rival_addr,
   // Resolved lines
   output logic o_sda,
   output logic o_alert_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] bit_r = 3'h7;
   logic lost_r = 1'b1;
   logic rival_oe;
   // Rival offers its address MSB first, drops out on a lost bit
   always_ff @(posedge i_clk) begin
      if (i_ara_start) begin
         bit_r <= 3'h6;
         lost_r <= 1'b0;
      end else if (i_bit_tick && bit_r != 3'h7) begin
         if (i_rival_addr[bit_r] && !o_sda) lost_r <= 1'b1;
         bit_r <= bit_r - 3'h1;
      end
   end
   assign rival_oe = i_rival_on && !lost_r && bit_r != 3'h7 && !i_rival_addr[bit_r];
   // Lines low while any party drives; rival releases alert once it won
   assign o_sda = !(i_dut_sda_oe || rival_oe);
   assign o_alert_n = !(i_dut_alert_oe || (i_rival_on && !(bit_r == 3'h7 && !lost_r)));
endmodule : bus_side_model
`default_nettype wire

/* File: dv/alert_response_tb.sv */
/* Bench of the alert response block with a rival device on the bus.
   Assumes package, design and checker files are compiled first. */
`default_nettype none
module alert_response_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import alert_resp_pkg::*;
   logic clk, rst_n, wr, rd, clr, start, tick, en, rv_on, sda, line_n;
   logic sda_out, sda_oe, al_out, al_oe, won, w;
   logic [FAULT_W-1:0] fault, wdata, rdata, status;
   logic [7:0] cmd;
   logic [1:0] p0, p1, p2;
   logic [6:0] rv_addr, own;
   int fails, total_checks;
   // Clock of 100 ns
   always #50 clk = ~clk;
   alert_response dut (.i_clk(clk), .i_reset_n(rst_n), .i_fault_active(fault),
      .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_cmd(cmd), .i_reg_wdata(wdata),
      .i_clear_faults(clr), .o_reg_rdata(rdata), .i_ara_start(start), .i_bit_tick(tick),
      .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_alert_n_out(al_out),
      .o_alert_n_oe(al_oe), .i_addr_select_pin_0(p0), .i_addr_select_pin_1(p1),
      .i_addr_select_pin_2(p2), .i_enable(en), .o_status_active(status),
      .o_own_addr(own), .o_ara_won(won));
   bus_side_model u_bus (.i_clk(clk), .i_dut_sda_oe(sda_oe), .i_dut_alert_oe(al_oe),
      .i_ara_start(start), .i_bit_tick(tick), .i_rival_on(rv_on), .i_rival_addr(rv_addr),
      .o_sda(sda), .o_alert_n(line_n));
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic al(input int n, input logic exp);
      repeat (n) @(posedge clk);
      #1 chk("alert_oe", {15'h0000, al_oe}, {15'h0000, exp});
   endtask : al
   task automatic wr_reg(input logic [7:0] c, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      cmd <= c;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      cmd <= c;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("rdata", rdata, exp);
   endtask : rd_chk
   // Response read: start, seven spaced bit ticks, then look for a win
   task automatic ara(output logic won_seen);
      won_seen = 1'b0;
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (7) begin
         repeat (4) @(posedge clk);
         tick <= 1'b1;
         @(posedge clk);
         tick <= 1'b0;
      end
      repeat (6) begin
         @(posedge clk);
         #1 if (won === 1'b1) won_seen = 1'b1;
      end
   endtask : ara
   task automatic t_addr();
      #1 chk("own_addr", {9'h000, own}, 16'h0040);
      @(posedge clk);
      en <= 1'b1;
      repeat (8) @(posedge clk);
      #1 chk("own_addr", {9'h000, own}, 16'h0017);
      $display("t_addr done");
   endtask : t_addr
   task automatic t_regs();
      rd_chk(8'hD8, 16'h0000);
      wr_reg(8'hD8, 16'hA5A5);
      rd_chk(8'hD8, 16'hA5A5);
      wr_reg(8'h33, 16'h1234);
      rd_chk(8'h33, 16'h0000);
      rd_chk(8'hD8, 16'hA5A5);
      wr_reg(8'hD8, 16'h0001);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_mask();
      fault <= 16'h0001;
      al(4, 1'b0);
      @(posedge clk);
      fault <= 16'h0003;
      al(3, 1'b1);
      chk("status", status, 16'h0003);
      $display("t_mask done");
   endtask : t_mask
   task automatic t_lose();
      rv_on <= 1'b1;
      ara(w);
      chk("won", {15'h0000, w}, 16'h0000);
      al(1, 1'b1);
      chk("line_n", {15'h0000, line_n}, 16'h0000);
      rv_on <= 1'b0;
      $display("t_lose done");
   endtask : t_lose
   task automatic t_win();
      ara(w);
      chk("won", {15'h0000, w}, 16'h0001);
      al(1, 1'b0);
      chk("status", status, 16'h0003);
      chk("line_n", {15'h0000, line_n}, 16'h0001);
      al(10, 1'b0);
      @(posedge clk);
      fault <= 16'h0007;
      al(3, 1'b1);
      ara(w);
      chk("won", {15'h0000, w}, 16'h0001);
      al(1, 1'b0);
      chk("status", status, 16'h0007);
      // Host services the alert with a clear-faults pulse
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      al(4, 1'b1);
      $display("t_win done");
   endtask : t_win
   // Rival with a higher address is outbid by our zero MSB, keeps its alert
   task automatic t_outbid();
      @(posedge clk);
      rv_addr <= 7'h50;
      rv_on <= 1'b1;
      ara(w);
      chk("won", {15'h0000, w}, 16'h0001);
      chk("line_n", {15'h0000, line_n}, 16'h0000);
      al(1, 1'b0);
      @(posedge clk);
      rv_on <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("line_n", {15'h0000, line_n}, 16'h0001);
      $display("t_outbid done");
   endtask : t_outbid
   task automatic stop_test();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   // Main sequence, reset held five cycles
   initial begin
      {clk, rst_n, wr, rd, clr, start, tick, en, rv_on} = '0;
      fault = '0;
      wdata = '0;
      cmd = '0;
      rv_addr = 7'h10;
      p0 = TRI_OPEN;
      p1 = TRI_HIGH;
      p2 = TRI_LOW;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_addr();
      t_regs();
      t_mask();
      t_lose();
      t_win();
      t_outbid();
      stop_test();
   end
   // Watchdog well past the expected run
   initial begin
      #200000;
      fails++;
      stop_test();
   end
endmodule : alert_response_tb
bind alert_response alert_response_checker u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
   .i_fault_active(i_fault_active), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
   .i_reg_cmd(i_reg_cmd), .i_clear_faults(i_clear_faults), .o_reg_rdata(o_reg_rdata),
   .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_alert_n_out(o_alert_n_out),
   .o_alert_n_oe(o_alert_n_oe), .o_status_active(o_status_active), .o_ara_won(o_ara_won));
`default_nettype wire
